/* File: common/icfe_pkg.sv */
// Operation
// - Eight external channels in four pairs A to D, even and odd.
// - Edge select one sets pending on rising edge, zero on falling edge.
// - Each external channel has its own mask bit suppressing its request.
// - Pair priority field; even channel LSB zero, odd channel LSB one.
// - Per-channel source select routes pin or internal peripheral request.
// - Channel D1 fed by non-maskable pin or wake-up unit, wake-up select.
// - Standard channels E0 to H1 carry CAN, I0 serial, I1 reserved.
// - Standard pending set by edge event, cleared by hardware on acknowledge.
// - Clearing a standard mask bit stops that channel's request.
// - Standard pair priority field; even LSB zero, odd LSB one.
// - Shared vector bits 1 to 4 track highest-priority pending channel.
// - Equal standard priorities resolved by daisy chain, E0 first, I1 last.
// - Standard overrun flag set when request repeats before acknowledge.
// - Top-level source bit high selects pin, low selects watchdog count end.
// - Top-level polarity bit picks pin rising edge when set, falling when clear; watchdog count end always on rising edge.
// - Selected top-level event sets the top-level pending bit.
// - Maskable top-level path needs enable bit and global enable both set.
// - During top-level service block all interrupts, DMA and top requests.
// - Top-level handling leaves global enable, priority level, save unchanged.
// - External pending cleared on acknowledge; software may set it.
// - Top-level pending cleared on acknowledge; software may set it.
// - Priorities three bits, zero highest, level seven never acknowledged.
// - External request needs mask, pending and global enable all one.
`default_nettype none
package icfe_pkg;
  localparam int NUM_EXT  = 8;
  localparam int NUM_STD  = 10;
  localparam int NUM_SYNC = 20;
  localparam int SYNC_STD = 8;
  localparam int SYNC_NMI = 18;
  localparam int SYNC_WDT = 19;

  localparam logic [7:0] ADDR_CENTRAL_INTERRUPT_CONTROL    = 8'hE6;
  localparam logic [7:0] ADDR_EXTERNAL_EDGE_SELECT    = 8'hF2;
  localparam logic [7:0] ADDR_EXTERNAL_PENDING_FLAGS    = 8'hF3;
  localparam logic [7:0] ADDR_EXTERNAL_MASK_BITS    = 8'hF4;
  localparam logic [7:0] ADDR_EXTERNAL_PAIR_PRIORITY   = 8'hF5;
  localparam logic [7:0] ADDR_EXTERNAL_VECTOR_AND_SOURCE    = 8'hF6;
  localparam logic [7:0] ADDR_NESTED_PRIORITY_SAVE    = 8'hF7;
  localparam logic [7:0] ADDR_SPEND_L = 8'hD0;
  localparam logic [7:0] ADDR_SPEND_H = 8'hD1;
  localparam logic [7:0] ADDR_SMASK_L = 8'hD2;
  localparam logic [7:0] ADDR_SMASK_H = 8'hD3;
  localparam logic [7:0] ADDR_SEDGE_L = 8'hD4;
  localparam logic [7:0] ADDR_SEDGE_H = 8'hD5;
  localparam logic [7:0] ADDR_SPRL_L  = 8'hD6;
  localparam logic [7:0] ADDR_SPRL_H  = 8'hD7;
  localparam logic [7:0] ADDR_SVEC    = 8'hD8;
  localparam logic [7:0] ADDR_SOVR_L  = 8'hD9;
  localparam logic [7:0] ADDR_SOVR_H  = 8'hDA;
  localparam logic [7:0] ADDR_WUCTL   = 8'hDB;
  localparam logic [7:0] ADDR_SRCSEL  = 8'hDC;

  localparam logic [7:0] RST_CENTRAL_INTERRUPT_CONTROL  = 8'h87;
  localparam logic [7:0] RST_EXTERNAL_EDGE_SELECT  = 8'h00;
  localparam logic [7:0] RST_EXTERNAL_PENDING_FLAGS  = 8'h00;
  localparam logic [7:0] RST_EXTERNAL_MASK_BITS  = 8'h00;
  localparam logic [7:0] RST_EXTERNAL_PAIR_PRIORITY = 8'hFF;
  localparam logic [7:0] RST_EXTERNAL_VECTOR_AND_SOURCE  = 8'h04;
  localparam logic [9:0] RST_SPRL  = 10'h3FF;

  localparam int CENTRAL_INTERRUPT_CONTROL_GCEN  = 7;
  localparam int CENTRAL_INTERRUPT_CONTROL_TOPLEVEL_PENDING  = 6;
  localparam int CENTRAL_INTERRUPT_CONTROL_TLI   = 5;
  localparam int CENTRAL_INTERRUPT_CONTROL_IEN   = 4;
  localparam int CENTRAL_INTERRUPT_CONTROL_IAM   = 3;
  localparam int EXTERNAL_VECTOR_AND_SOURCE_TOPLEVEL_EDGE_POLARITY = 3;
  localparam int EXTERNAL_VECTOR_AND_SOURCE_TOPLEVEL_SOURCE_SEL  = 2;
  localparam int EXTERNAL_VECTOR_AND_SOURCE_CHAN_A_EVEN_SOURCE_SEL  = 0;
  localparam int NESTED_PRIORITY_SAVE_TOPLEVEL_NONMASK_ENABLE  = 7;
  localparam int WUCTL_CHAN_D_ODD_SOURCE_SEL = 0;

  localparam logic [2:0] PRIO_NEVER = 3'h7;
endpackage : icfe_pkg
`default_nettype wire

/* File: hdl/icfe_top.sv */
// Design decision made here: the strobed register port.
`default_nettype none
module icfe_top (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic [6:0] ext_pin_i,
  input  wire logic       nmi_pin_i,
  input  wire logic [6:0] periph_req_i,
  input  wire logic       wakeup_req_i,
  input  wire logic [8:0] std_src_i,
  input  wire logic       wdt_eoc_i,
  input  wire logic [7:0] ack_ext_i,
  input  wire logic [9:0] ack_std_i,
  input  wire logic       ack_top_i,
  input  wire logic       iret_top_i,
  output logic      [7:0] ext_req_o,
  output logic            std_req_o,
  output logic      [2:0] std_prio_o,
  output logic            top_req_o,
  output logic            dma_block_o
);
  localparam int NE = icfe_pkg::NUM_EXT;
  localparam int NS = icfe_pkg::NUM_STD;
  localparam int NY = icfe_pkg::NUM_SYNC;

  // Control and status state
  logic          gcen;
  logic          toplevel_pending;
  logic          toplevel_maskable_enable;
  logic          global_int_enable;
  logic          iam;
  logic [2:0]    current_priority_level;
  logic [NE-1:0] edge_sel;
  logic [NE-1:0] ext_pend;
  logic [NE-1:0] ext_mask;
  logic [7:0]    ext_prl;
  logic [7:0]    external_vector_and_source;
  logic [6:0]    nested_priority_save_save;
  logic          toplevel_nonmask_enable;
  logic [5:0]    src_mid;
  logic          chan_d_odd_source_sel;
  logic [NS-1:0] std_pend;
  logic [NS-1:0] std_mask;
  logic [NS-1:0] std_edge;
  logic [NS-1:0] std_prl;
  logic [2:0]    std_vbase;
  logic [NS-1:0] std_ovr;
  logic [NY-1:0] sync_a;
  logic [NY-1:0] sync_b;
  logic [NY-1:0] sync_c;

  // Register decode
  wire wr_central_interrupt_control   = wr_i && (addr_i == icfe_pkg::ADDR_CENTRAL_INTERRUPT_CONTROL);
  wire wr_external_edge_select   = wr_i && (addr_i == icfe_pkg::ADDR_EXTERNAL_EDGE_SELECT);
  wire wr_external_pending_flags   = wr_i && (addr_i == icfe_pkg::ADDR_EXTERNAL_PENDING_FLAGS);
  wire wr_external_mask_bits   = wr_i && (addr_i == icfe_pkg::ADDR_EXTERNAL_MASK_BITS);
  wire wr_external_pair_priority  = wr_i && (addr_i == icfe_pkg::ADDR_EXTERNAL_PAIR_PRIORITY);
  wire wr_external_vector_and_source   = wr_i && (addr_i == icfe_pkg::ADDR_EXTERNAL_VECTOR_AND_SOURCE);
  wire wr_nested_priority_save   = wr_i && (addr_i == icfe_pkg::ADDR_NESTED_PRIORITY_SAVE);
  wire wr_spendl = wr_i && (addr_i == icfe_pkg::ADDR_SPEND_L);
  wire wr_spendh = wr_i && (addr_i == icfe_pkg::ADDR_SPEND_H);
  wire wr_smaskl = wr_i && (addr_i == icfe_pkg::ADDR_SMASK_L);
  wire wr_smaskh = wr_i && (addr_i == icfe_pkg::ADDR_SMASK_H);
  wire wr_sedgel = wr_i && (addr_i == icfe_pkg::ADDR_SEDGE_L);
  wire wr_sedgeh = wr_i && (addr_i == icfe_pkg::ADDR_SEDGE_H);
  wire wr_sprll  = wr_i && (addr_i == icfe_pkg::ADDR_SPRL_L);
  wire wr_sprlh  = wr_i && (addr_i == icfe_pkg::ADDR_SPRL_H);
  wire wr_svec   = wr_i && (addr_i == icfe_pkg::ADDR_SVEC);
  wire wr_sovrl  = wr_i && (addr_i == icfe_pkg::ADDR_SOVR_L);
  wire wr_sovrh  = wr_i && (addr_i == icfe_pkg::ADDR_SOVR_H);
  wire wr_wuctl  = wr_i && (addr_i == icfe_pkg::ADDR_WUCTL);
  wire wr_srcsel = wr_i && (addr_i == icfe_pkg::ADDR_SRCSEL);

  // Source steering: bit set means the internal peripheral drives the channel
  wire [NE-1:0] ext_sel = {chan_d_odd_source_sel, src_mid, external_vector_and_source[icfe_pkg::EXTERNAL_VECTOR_AND_SOURCE_CHAN_A_EVEN_SOURCE_SEL]};
  wire [NE-1:0] ext_pinv  = {nmi_pin_i, ext_pin_i};
  wire [NE-1:0] ext_perv  = {wakeup_req_i, periph_req_i};
  wire [NE-1:0] ext_raw   = (ext_sel & ext_perv) | (~ext_sel & ext_pinv);
  // I1 has no source
  wire [NS-1:0] std_raw   = {1'b0, std_src_i};
  wire [NY-1:0] raw_in    = {wdt_eoc_i, nmi_pin_i, std_raw, ext_raw};

  // Edge detection on second and third sample stages
  wire [NY-1:0] rise = sync_b & ~sync_c;
  wire [NY-1:0] fall = ~sync_b & sync_c;

  wire [NE-1:0] ext_evt = (edge_sel & rise[NE-1:0])
                        | (~edge_sel & fall[NE-1:0]);
  wire [NS-1:0] std_rise = rise[icfe_pkg::SYNC_STD +: NS];
  wire [NS-1:0] std_fall = fall[icfe_pkg::SYNC_STD +: NS];
  wire [NS-1:0] std_evt  = (std_edge & std_rise) | (~std_edge & std_fall);

  wire toplevel_source_sel  = external_vector_and_source[icfe_pkg::EXTERNAL_VECTOR_AND_SOURCE_TOPLEVEL_SOURCE_SEL];
  wire toplevel_edge_polarity = external_vector_and_source[icfe_pkg::EXTERNAL_VECTOR_AND_SOURCE_TOPLEVEL_EDGE_POLARITY];
  wire nmi_evt = toplevel_edge_polarity ? rise[icfe_pkg::SYNC_NMI]
                       : fall[icfe_pkg::SYNC_NMI];
  wire top_evt = toplevel_source_sel ? nmi_evt : rise[icfe_pkg::SYNC_WDT];

  // Per-channel priority levels
  logic [2:0] ext_lvl [NE];
  logic [2:0] std_lvl [NS];
  logic [NE-1:0] ext_lvl_ok;
  logic [NS-1:0] std_elig;

  for (genvar g = 0; g < NE; g++) begin : g_ext_lvl
    assign ext_lvl[g] = {ext_prl[2*(g/2)+1], ext_prl[2*(g/2)],
                         1'(g % 2)};
    assign ext_lvl_ok[g] = ext_lvl[g] != icfe_pkg::PRIO_NEVER;
  end

  for (genvar g = 0; g < NS; g++) begin : g_std_lvl
    assign std_lvl[g] = {std_prl[2*(g/2)+1], std_prl[2*(g/2)],
                         1'(g % 2)};
    assign std_elig[g] = std_pend[g] && std_mask[g]
                      && (std_lvl[g] != icfe_pkg::PRIO_NEVER);
  end

  // Daisy-chain winner: strict less-than keeps the earlier channel on a tie
  logic [3:0] win_idx;
  logic [2:0] win_lvl;
  logic       win_found;

  always_comb begin
    win_idx   = 4'h0;
    win_lvl   = icfe_pkg::PRIO_NEVER;
    win_found = 1'b0;
    for (int k = 0; k < NS; k++) begin
      if (std_elig[k] && (!win_found || std_lvl[k] < win_lvl)) begin
        win_idx   = 4'(k);
        win_lvl   = std_lvl[k];
        win_found = 1'b1;
      end
    end
  end

  wire [7:0] svec_rd = {std_vbase, win_idx, 1'b0};

  // Next state of event-driven flags; hardware set wins over any clear
  wire [NE-1:0] next_ext_pend = wr_external_pending_flags
                              ? (wdata_i | ext_evt)
                              : ((ext_pend & ~ack_ext_i) | ext_evt);
  wire [NS-1:0] std_wdata = {wdata_i[1:0], wdata_i};
  wire [NS-1:0] std_wmask = {{2{wr_spendh}}, {8{wr_spendl}}};
  wire [NS-1:0] std_kept  = (std_wmask & std_wdata)
                          | (~std_wmask & std_pend & ~ack_std_i);
  wire [NS-1:0] next_std_pend = std_kept | std_evt;
  wire [NS-1:0] ovr_set  = std_evt & std_pend & ~ack_std_i;
  wire [NS-1:0] ovr_wm   = {{2{wr_sovrh}}, {8{wr_sovrl}}};
  wire [NS-1:0] next_std_ovr = (std_ovr & (~ovr_wm | std_wdata)) | ovr_set;
  wire next_toplevel_pending = (wr_central_interrupt_control ? wdata_i[icfe_pkg::CENTRAL_INTERRUPT_CONTROL_TOPLEVEL_PENDING]
                            : (toplevel_pending & ~ack_top_i)) | top_evt;
  wire next_toplevel_nonmask_enable = toplevel_nonmask_enable | (wr_nested_priority_save & wdata_i[icfe_pkg::NESTED_PRIORITY_SAVE_TOPLEVEL_NONMASK_ENABLE]);
  wire next_in_top = ack_top_i | (dma_block_o & ~iret_top_i);

  // Requests toward the core, all held off during top-level service
  wire open_gate = global_int_enable && !dma_block_o;
  wire [NE-1:0] next_ext_req = ext_pend & ext_mask & ext_lvl_ok
                             & {NE{open_gate}};
  wire next_std_req = win_found && open_gate;
  wire next_top_req = toplevel_pending && !dma_block_o
                   && ((toplevel_maskable_enable && global_int_enable) || toplevel_nonmask_enable);

  // Read selection
  wire [7:0] central_interrupt_control_rd = {gcen, toplevel_pending, toplevel_maskable_enable, global_int_enable, iam, current_priority_level};
  wire [7:0] rd_mux =
      (addr_i == icfe_pkg::ADDR_CENTRAL_INTERRUPT_CONTROL)    ? central_interrupt_control_rd :
      (addr_i == icfe_pkg::ADDR_EXTERNAL_EDGE_SELECT)    ? edge_sel :
      (addr_i == icfe_pkg::ADDR_EXTERNAL_PENDING_FLAGS)    ? ext_pend :
      (addr_i == icfe_pkg::ADDR_EXTERNAL_MASK_BITS)    ? ext_mask :
      (addr_i == icfe_pkg::ADDR_EXTERNAL_PAIR_PRIORITY)   ? ext_prl :
      (addr_i == icfe_pkg::ADDR_EXTERNAL_VECTOR_AND_SOURCE)    ? external_vector_and_source :
      (addr_i == icfe_pkg::ADDR_NESTED_PRIORITY_SAVE)    ? {toplevel_nonmask_enable, nested_priority_save_save} :
      (addr_i == icfe_pkg::ADDR_SPEND_L) ? std_pend[7:0] :
      (addr_i == icfe_pkg::ADDR_SPEND_H) ? {6'h00, std_pend[9:8]} :
      (addr_i == icfe_pkg::ADDR_SMASK_L) ? std_mask[7:0] :
      (addr_i == icfe_pkg::ADDR_SMASK_H) ? {6'h00, std_mask[9:8]} :
      (addr_i == icfe_pkg::ADDR_SEDGE_L) ? std_edge[7:0] :
      (addr_i == icfe_pkg::ADDR_SEDGE_H) ? {6'h00, std_edge[9:8]} :
      (addr_i == icfe_pkg::ADDR_SPRL_L)  ? std_prl[7:0] :
      (addr_i == icfe_pkg::ADDR_SPRL_H)  ? {6'h00, std_prl[9:8]} :
      (addr_i == icfe_pkg::ADDR_SVEC)    ? svec_rd :
      (addr_i == icfe_pkg::ADDR_SOVR_L)  ? std_ovr[7:0] :
      (addr_i == icfe_pkg::ADDR_SOVR_H)  ? {6'h00, std_ovr[9:8]} :
      (addr_i == icfe_pkg::ADDR_WUCTL)   ? {7'h00, chan_d_odd_source_sel} :
      (addr_i == icfe_pkg::ADDR_SRCSEL)  ? {1'b0, src_mid, 1'b0} :
                                           8'h00;

  // Input synchroniser and previous-sample stage
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_a <= '0;
      sync_b <= '0;
      sync_c <= '0;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // Central control; acknowledges never touch enable, level or save bits
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gcen <= icfe_pkg::RST_CENTRAL_INTERRUPT_CONTROL[icfe_pkg::CENTRAL_INTERRUPT_CONTROL_GCEN];
      toplevel_pending <= icfe_pkg::RST_CENTRAL_INTERRUPT_CONTROL[icfe_pkg::CENTRAL_INTERRUPT_CONTROL_TOPLEVEL_PENDING];
      toplevel_maskable_enable  <= icfe_pkg::RST_CENTRAL_INTERRUPT_CONTROL[icfe_pkg::CENTRAL_INTERRUPT_CONTROL_TLI];
      global_int_enable  <= icfe_pkg::RST_CENTRAL_INTERRUPT_CONTROL[icfe_pkg::CENTRAL_INTERRUPT_CONTROL_IEN];
      iam  <= icfe_pkg::RST_CENTRAL_INTERRUPT_CONTROL[icfe_pkg::CENTRAL_INTERRUPT_CONTROL_IAM];
      current_priority_level  <= icfe_pkg::RST_CENTRAL_INTERRUPT_CONTROL[2:0];
      toplevel_nonmask_enable <= 1'b0;
      nested_priority_save_save <= 7'h00;
      dma_block_o <= 1'b0;
    end else begin
      toplevel_pending <= next_toplevel_pending;
      toplevel_nonmask_enable <= next_toplevel_nonmask_enable;
      dma_block_o <= next_in_top;
      if (wr_central_interrupt_control) begin
        gcen <= wdata_i[icfe_pkg::CENTRAL_INTERRUPT_CONTROL_GCEN];
        toplevel_maskable_enable  <= wdata_i[icfe_pkg::CENTRAL_INTERRUPT_CONTROL_TLI];
        global_int_enable  <= wdata_i[icfe_pkg::CENTRAL_INTERRUPT_CONTROL_IEN];
        iam  <= wdata_i[icfe_pkg::CENTRAL_INTERRUPT_CONTROL_IAM];
        current_priority_level  <= wdata_i[2:0];
      end
      if (wr_nested_priority_save) begin
        nested_priority_save_save <= wdata_i[6:0];
      end
    end
  end

  // External channel configuration and pending flags
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      edge_sel <= icfe_pkg::RST_EXTERNAL_EDGE_SELECT;
      ext_pend <= icfe_pkg::RST_EXTERNAL_PENDING_FLAGS;
      ext_mask <= icfe_pkg::RST_EXTERNAL_MASK_BITS;
      ext_prl  <= icfe_pkg::RST_EXTERNAL_PAIR_PRIORITY;
      external_vector_and_source     <= icfe_pkg::RST_EXTERNAL_VECTOR_AND_SOURCE;
      src_mid  <= 6'h00;
      chan_d_odd_source_sel     <= 1'b0;
    end else begin
      ext_pend <= next_ext_pend;
      if (wr_external_edge_select)   edge_sel <= wdata_i;
      if (wr_external_mask_bits)   ext_mask <= wdata_i;
      if (wr_external_pair_priority)  ext_prl  <= wdata_i;
      if (wr_external_vector_and_source)   external_vector_and_source     <= wdata_i;
      if (wr_srcsel) src_mid  <= wdata_i[6:1];
      if (wr_wuctl)  chan_d_odd_source_sel     <= wdata_i[icfe_pkg::WUCTL_CHAN_D_ODD_SOURCE_SEL];
    end
  end

  // Standard channel configuration, pending and overrun flags
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      std_pend  <= '0;
      std_mask  <= '0;
      std_edge  <= '0;
      std_prl   <= icfe_pkg::RST_SPRL;
      std_vbase <= 3'h0;
      std_ovr   <= '0;
    end else begin
      std_pend <= next_std_pend;
      std_ovr  <= next_std_ovr;
      if (wr_smaskl) std_mask[7:0] <= wdata_i;
      if (wr_smaskh) std_mask[9:8] <= wdata_i[1:0];
      if (wr_sedgel) std_edge[7:0] <= wdata_i;
      if (wr_sedgeh) std_edge[9:8] <= wdata_i[1:0];
      if (wr_sprll)  std_prl[7:0]  <= wdata_i;
      if (wr_sprlh)  std_prl[9:8]  <= wdata_i[1:0];
      if (wr_svec)   std_vbase     <= wdata_i[7:5];
    end
  end

  // Registered outputs toward the core and the bus
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o    <= 8'h00;
      ext_req_o  <= 8'h00;
      std_req_o  <= 1'b0;
      std_prio_o <= icfe_pkg::PRIO_NEVER;
      top_req_o  <= 1'b0;
    end else begin
      rdata_o    <= rd_i ? rd_mux : 8'h00;
      ext_req_o  <= next_ext_req;
      std_req_o  <= next_std_req;
      std_prio_o <= win_lvl;
      top_req_o  <= next_top_req;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  property p_edge_sets_pend;
    (|ext_evt) |=> ((ext_pend & $past(ext_evt)) == $past(ext_evt));
  endproperty
  a_edge_sets_pend: assert property (p_edge_sets_pend)
    else $error("external edge did not set pending");

  property p_mask_blocks;
    (ext_req_o & ~$past(ext_mask)) == 8'h00;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks)
    else $error("masked external channel raised request");

  property p_ext_needs_ien;
    (|ext_req_o) |-> ($past(global_int_enable) && (ext_req_o & ~$past(ext_pend)) == 8'h00);
  endproperty
  a_ext_needs_ien: assert property (p_ext_needs_ien)
    else $error("external request without enable or pending");

  property p_std_ack_clears;
    (|(ack_std_i & ~std_evt)) |=>
      ((std_pend & $past(ack_std_i & ~std_evt & ~std_wmask)) == 10'h000);
  endproperty
  a_std_ack_clears: assert property (p_std_ack_clears)
    else $error("acknowledged standard pending not cleared");

  property p_overrun;
    (|ovr_set) |=> ((std_ovr & $past(ovr_set)) == $past(ovr_set));
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun flag not set on repeated request");

  property p_std_prio_ok;
    std_req_o |-> (std_prio_o != icfe_pkg::PRIO_NEVER);
  endproperty
  a_std_prio_ok: assert property (p_std_prio_ok)
    else $error("level seven request forwarded");

  property p_top_evt_pend;
    top_evt |=> toplevel_pending;
  endproperty
  a_top_evt_pend: assert property (p_top_evt_pend)
    else $error("top-level event did not set pending");

  property p_top_maskable;
    (top_req_o && !$past(toplevel_nonmask_enable)) |-> $past(toplevel_maskable_enable && global_int_enable && toplevel_pending);
  endproperty
  a_top_maskable: assert property (p_top_maskable)
    else $error("maskable top-level request without enables");

  property p_toplevel_nonmask_enable_sticky;
    toplevel_nonmask_enable |=> toplevel_nonmask_enable [*2];
  endproperty
  a_toplevel_nonmask_enable_sticky: assert property (p_toplevel_nonmask_enable_sticky)
    else $error("non-maskable enable cleared without reset");

  property p_service_blocks;
    dma_block_o |=> (!top_req_o && !std_req_o && ext_req_o == 8'h00);
  endproperty
  a_service_blocks: assert property (p_service_blocks)
    else $error("request issued during top-level service");

  property p_top_ack_clears;
    (ack_top_i && !top_evt && !wr_central_interrupt_control) |=> (!toplevel_pending && dma_block_o);
  endproperty
  a_top_ack_clears: assert property (p_top_ack_clears)
    else $error("top-level acknowledge did not clear pending");

  property p_pin_latency;
    (!ext_sel[0] && edge_sel[0] && !ext_pin_i[0]) ##1
      ((ext_pin_i[0] && !ext_sel[0] && edge_sel[0]) [*3])
      |=> ext_pend[0];
  endproperty
  a_pin_latency: assert property (p_pin_latency)
    else $error("pin edge not pending after synchroniser delay");
endmodule : icfe_top
`default_nettype wire

/* File: bench/icfe_cpu_model.sv */
`default_nettype none
module icfe_cpu_model (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       en_i,
  input  wire logic [7:0] ext_req_i,
  input  wire logic       top_req_i,
  output logic      [7:0] ack_ext_o,
  output logic            ack_top_o,
  output logic            iret_top_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int ext_cnt;
  int top_cnt;
  // Acks the lowest requesting channel two cycles late, then lets the
  // request fall before looking again so one request gets one ack
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_cnt    <= 0;
      top_cnt    <= 0;
      ack_ext_o  <= 8'h00;
      ack_top_o  <= 1'b0;
      iret_top_o <= 1'b0;
    end else begin
      ack_ext_o  <= 8'h00;
      ack_top_o  <= 1'b0;
      iret_top_o <= 1'b0;
      if (ext_cnt != 0 || (en_i && ext_req_i != 8'h00)) begin
        ext_cnt <= (ext_cnt == 5) ? 0 : ext_cnt + 1;
      end
      if (ext_cnt == 2) begin
        ack_ext_o <= ext_req_i & (~ext_req_i + 8'h01);
      end
      if (top_cnt != 0 || (en_i && top_req_i)) begin
        top_cnt <= (top_cnt == 14) ? 0 : top_cnt + 1;
      end
      ack_top_o  <= (top_cnt == 2);
      iret_top_o <= (top_cnt == 10);
    end
  end
endmodule : icfe_cpu_model
`default_nettype wire

/* File: bench/test_interrupt_channel_front_end.sv */
`default_nettype none
module test_interrupt_channel_front_end;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock_i, rst_n_i, wr_s, rd_s, nmi, wdt, ack_top, iret, en;
  logic [7:0] addr, wdata, rdata_o, ext_req_o, ack_ext;
  logic [6:0] ext_pin, periph;
  logic [8:0] std_src;
  logic [9:0] ack_std;
  logic       wkup;
  logic [13:0] obs;
  logic       std_req_o, top_req_o, dma_block_o;
  logic [2:0] std_prio_o;
  int         error_cnt, check_count;
  logic [16:0] rows [15] = '{17'h0E687, 17'h0F200, 17'h0F300, 17'h0F400,
    17'h0F5FF, 17'h0F604, 17'h0F700, 17'h01000, 17'h110AA, 17'h01000,
    17'h1F5E4, 17'h0F5E4, 17'h1F780, 17'h1F700, 17'h0F780};
  icfe_top dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata_o),
    .ext_pin_i(ext_pin), .nmi_pin_i(nmi), .periph_req_i(periph),
    .wakeup_req_i(wkup), .std_src_i(std_src), .wdt_eoc_i(wdt),
    .ack_ext_i(ack_ext), .ack_std_i(ack_std), .ack_top_i(ack_top),
    .iret_top_i(iret), .ext_req_o(ext_req_o), .std_req_o(std_req_o),
    .std_prio_o(std_prio_o), .top_req_o(top_req_o),
    .dma_block_o(dma_block_o));
  icfe_cpu_model cpu (.clock_i(clock_i), .rst_n_i(rst_n_i), .en_i(en),
    .ext_req_i(ext_req_o), .top_req_i(top_req_o), .ack_ext_o(ack_ext),
    .ack_top_o(ack_top), .iret_top_o(iret));
  // Outputs as they stood after the last rising edge, free of edge races
  always @(negedge clock_i) begin
    obs <= {std_prio_o, std_req_o, dma_block_o, top_req_o, ext_req_o};
  end
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clock_i);
    wr_s  <= 1'b0;
    @(posedge clock_i);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] g;
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock_i);
    rd_s <= 1'b0;
    #1 g = rdata_o;
    chk("rdata", e, g);
    @(posedge clock_i);
  endtask : rdc
  task automatic wait_on(input int s, input logic v);
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge clock_i);
      if (obs[s] === v) break;
    end
    check_count++;
    if (i == 20) begin
      error_cnt++;
      $display("BAD wait %0d exp %b got %b", s, v, obs[s]);
      close_out();
    end
  endtask : wait_on
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  initial begin
    {rst_n_i, wr_s, rd_s, nmi, wdt, en, wkup, addr, wdata} = '0;
    {ext_pin, periph, std_src, ack_std} = '0;
    step(3);
    rst_n_i <= 1'b1;
    step(1);
    for (int r = 0; r < 15; r++) begin
      if (rows[r][16]) wr(rows[r][15:8], rows[r][7:0]);
      else rdc(rows[r][15:8], rows[r][7:0]);
    end
    wr(8'hF4, 8'hFF);
    wr(8'hF2, 8'h01);
    wr(8'hE6, 8'h17);
    en <= 1'b1;
    ext_pin <= 7'h01;
    wait_on(0, 1'b1);
    wait_on(0, 1'b0);
    en <= 1'b0;
    ext_pin <= 7'h03;
    step(5);
    rdc(8'hF3, 8'h00);
    ext_pin <= 7'h01;
    step(5);
    rdc(8'hF3, 8'h02);
    chk("ext_req", 8'h02, obs[7:0]);
    wr(8'hF3, 8'h00);
    wr(8'hF4, 8'hFE);
    ext_pin <= 7'h00;
    step(3);
    ext_pin <= 7'h01;
    step(5);
    rdc(8'hF3, 8'h01);
    chk("ext_req", 8'h00, obs[7:0]);
    wr(8'hF4, 8'hFF);
    wr(8'hE6, 8'h07);
    wr(8'hF3, 8'h05);
    step(2);
    chk("ext_req", 8'h00, obs[7:0]);
    wr(8'hE6, 8'h17);
    step(2);
    chk("ext_req", 8'h05, obs[7:0]);
    wr(8'hF3, 8'h00);
    wr(8'hF6, 8'h05);
    ext_pin <= 7'h00;
    step(3);
    ext_pin <= 7'h01;
    step(5);
    rdc(8'hF3, 8'h00);
    periph <= 7'h01;
    step(5);
    rdc(8'hF3, 8'h01);
    wr(8'hF3, 8'h00);
    wr(8'hF6, 8'h04);
    wr(8'hD4, 8'hFF);
    wr(8'hD5, 8'h01);
    wr(8'hD2, 8'hFF);
    wr(8'hD3, 8'h03);
    std_src <= 9'h014;
    step(5);
    chk("std_prio", 8'h06, {5'h00, obs[13:11]});
    chk("std_req", 8'h01, {7'h00, obs[10]});
    rdc(8'hD8, 8'h04);
    std_src <= 9'h000;
    step(3);
    std_src <= 9'h010;
    step(5);
    rdc(8'hD9, 8'h10);
    ack_std <= 10'h004;
    step(1);
    ack_std <= 10'h000;
    step(3);
    rdc(8'hD8, 8'h08);
    wr(8'hD2, 8'h00);
    step(3);
    chk("std_req", 8'h00, {7'h00, obs[10]});
    en <= 1'b1;
    nmi <= 1'b1;
    step(3);
    nmi <= 1'b0;
    wait_on(8, 1'b1);
    wait_on(9, 1'b1);
    wr(8'hF3, 8'h01);
    step(2);
    chk("ext_req", 8'h00, obs[7:0]);
    wait_on(9, 1'b0);
    wait_on(0, 1'b1);
    rdc(8'hE6, 8'h17);
    rdc(8'hF7, 8'h80);
    wr(8'hF3, 8'h00);
    wr(8'hDB, 8'h01);
    wkup <= 1'b1;
    step(3);
    wkup <= 1'b0;
    step(5);
    rdc(8'hF3, 8'h80);
    wr(8'hF6, 8'h00);
    wdt <= 1'b1;
    wait_on(8, 1'b1);
    close_out();
  end
endmodule : test_interrupt_channel_front_end
`default_nettype wire
